// ===== common/tmrctl_pkg.sv
// Package for the timer one control block: register layout, reset values and prescale codes.
// Assumes a single 125 MHz clock domain and a plain address/strobe register port.
package tmrctl_pkg;
  localparam int unsigned TMRCTL_ADDR_W = 4;
  localparam logic [3:0] TMRCTL_CONTROL_OFS = 4'h0;
  localparam logic [3:0] TMRCTL_COUNT_LO_OFS = 4'h1;
  localparam logic [3:0] TMRCTL_COUNT_HI_OFS = 4'h2;
  localparam logic [7:0] TMRCTL_CONTROL_RESET = 8'h00;
  localparam logic [15:0] TMRCTL_COUNT_RESET = 16'h0000;
  localparam logic [7:0] TMRCTL_CONTROL_MASK = 8'h3f;
  localparam int unsigned TMRCTL_RUN_BIT = 0;
  localparam int unsigned TMRCTL_SRC_BIT = 1;
  localparam int unsigned TMRCTL_SYNC_BIT = 2;
  localparam int unsigned TMRCTL_OSC_BIT = 3;
  localparam int unsigned TMRCTL_PS_LSB = 4;
  localparam logic [1:0] TMRCTL_PS_DIV1 = 2'h0;
  localparam logic [1:0] TMRCTL_PS_DIV2 = 2'h1;
  localparam logic [1:0] TMRCTL_PS_DIV4 = 2'h2;
  localparam logic [1:0] TMRCTL_PS_DIV8 = 2'h3;
  // Internal instruction clock is the core clock divided by four; the two-bit divider ticks when it reaches this last count
  localparam logic [1:0] TMRCTL_INSTR_DIV_LAST = 2'h3;
endpackage : tmrctl_pkg

// ===== design/tmrctl_timer.sv
// Timer one control block: control register, clock source select, prescaler and 16-bit count.
// Assumes a register master on the same clock; the count pin is asynchronous to it.
module tmrctl_timer
  import tmrctl_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdData,
  input wire logic externalCountPin,
  output logic oscPowerOn,
  output logic [15:0] countValue
);

  typedef struct packed {
    logic [7:0] control;
    logic [15:0] count;
    logic [2:0] prescale;
    logic [1:0] instrDiv;
    logic pinMeta;
    logic pinSync;
    // Third pin stage keeps the synchronised path one flop behind the bypass
    logic pinAligned;
    logic pinPrev;
    // Cleared on stop or source change so a stale falling edge cannot arm a new run
    logic armed;
    logic [7:0] rdData;
  } tmrctl_state_type;

  tmrctl_state_type s_q;
  tmrctl_state_type s_d;

  logic [1:0] psSel;
  logic extSel;
  logic pinLevel;
  logic rise;
  logic fall;
  logic srcTick;
  logic psTick;

  assign psSel = s_q.control[TMRCTL_PS_LSB +: 2];
  assign extSel = s_q.control[TMRCTL_SRC_BIT];
  // Bypass taps the second flop, synchronised path the third; the first flop feeds nothing else
  assign pinLevel = s_q.control[TMRCTL_SYNC_BIT] ? s_q.pinSync : s_q.pinAligned;
  assign rise = pinLevel & ~s_q.pinPrev;
  assign fall = ~pinLevel & s_q.pinPrev;

  always_comb begin
    if (extSel) begin
      srcTick = rise & s_q.armed;
    end else begin
      srcTick = (s_q.instrDiv == TMRCTL_INSTR_DIV_LAST);
    end
    case (psSel)
      TMRCTL_PS_DIV1: psTick = srcTick;
      TMRCTL_PS_DIV2: psTick = srcTick & s_q.prescale[0];
      TMRCTL_PS_DIV4: psTick = srcTick & (&s_q.prescale[1:0]);
      TMRCTL_PS_DIV8: psTick = srcTick & (&s_q.prescale);
      default: psTick = 1'b0;
    endcase
  end

  always_comb begin
    s_d = s_q;
    s_d.pinMeta = externalCountPin;
    s_d.pinSync = s_q.pinMeta;
    s_d.pinAligned = s_q.pinSync;
    s_d.pinPrev = pinLevel;
    s_d.instrDiv = s_q.instrDiv + 2'h1;
    if (s_q.control[TMRCTL_RUN_BIT]) begin
      if (srcTick) begin
        s_d.prescale = s_q.prescale + 3'h1;
      end
      if (psTick) begin
        s_d.count = s_q.count + 16'h0001;
      end
      if (extSel && fall) begin
        s_d.armed = 1'b1;
      end
    end else begin
      s_d.armed = 1'b0;
    end
    if (regWrite) begin
      case (regAddr)
        TMRCTL_CONTROL_OFS: begin
          s_d.control = regWrData & TMRCTL_CONTROL_MASK;
          // Changing source or stopping re-arms the falling-edge wait
          if (!regWrData[TMRCTL_RUN_BIT] || (regWrData[TMRCTL_SRC_BIT] != extSel)) begin
            s_d.armed = 1'b0;
          end
          s_d.prescale = 3'h0;
        end
        TMRCTL_COUNT_LO_OFS: s_d.count[7:0] = regWrData;
        TMRCTL_COUNT_HI_OFS: s_d.count[15:8] = regWrData;
        default: ;
      endcase
    end
    s_d.rdData = 8'h00;
    if (regRead) begin
      case (regAddr)
        TMRCTL_CONTROL_OFS: s_d.rdData = s_q.control;
        TMRCTL_COUNT_LO_OFS: s_d.rdData = s_q.count[7:0];
        TMRCTL_COUNT_HI_OFS: s_d.rdData = s_q.count[15:8];
        default: s_d.rdData = 8'h00;
      endcase
    end
  end

  // Pin flops clear low with the rest, matching the idle pin so no false edge follows reset
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s_q <= '0;
      s_q.control <= TMRCTL_CONTROL_RESET;
      s_q.count <= TMRCTL_COUNT_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign regRdData = s_q.rdData;
  assign oscPowerOn = s_q.control[TMRCTL_OSC_BIT];
  assign countValue = s_q.count;

  // Count path
  stop_holds_a: assert property (@(posedge clock) disable iff (sys_rst)
    (!s_q.control[TMRCTL_RUN_BIT] && !regWrite) |=> $stable(s_q.count))
    else $error("count moved while stopped");
  wrap_step_a: assert property (@(posedge clock) disable iff (sys_rst)
    (psTick && s_q.control[TMRCTL_RUN_BIT] && !regWrite) |=> s_q.count == $past(s_q.count) + 16'h0001)
    else $error("count did not step by one");
  tick_only_a: assert property (@(posedge clock) disable iff (sys_rst)
    (s_q.control[TMRCTL_RUN_BIT] && !psTick && !regWrite) |=> $stable(s_q.count))
    else $error("count moved without a tick");
  lo_write_a: assert property (@(posedge clock) disable iff (sys_rst)
    (regWrite && regAddr == TMRCTL_COUNT_LO_OFS) |=> s_q.count[7:0] == $past(regWrData))
    else $error("count low byte write lost");
  hi_write_a: assert property (@(posedge clock) disable iff (sys_rst)
    (regWrite && regAddr == TMRCTL_COUNT_HI_OFS) |=> s_q.count[15:8] == $past(regWrData))
    else $error("count high byte write lost");

  // Clock source selection
  internal_rate_a: assert property (@(posedge clock) disable iff (sys_rst)
    (!extSel && srcTick) |=> !srcTick[*3])
    else $error("internal tick faster than quarter rate");
  quarter_rate_a: assert property (@(posedge clock) disable iff (sys_rst)
    (!extSel && srcTick) |-> ##4 (extSel || srcTick))
    else $error("internal tick slower than quarter rate");
  internal_pin_a: assert property (@(posedge clock) disable iff (sys_rst)
    (!extSel && s_q.instrDiv != TMRCTL_INSTR_DIV_LAST) |-> !srcTick)
    else $error("internal source took a pin tick");
  ext_edge_a: assert property (@(posedge clock) disable iff (sys_rst)
    (extSel && srcTick) |-> (pinLevel && !s_q.pinPrev))
    else $error("external tick without rising edge");
  unarmed_hold_a: assert property (@(posedge clock) disable iff (sys_rst)
    (extSel && !s_q.armed) |-> !srcTick)
    else $error("external tick before falling edge");
  stop_disarm_a: assert property (@(posedge clock) disable iff (sys_rst)
    !s_q.control[TMRCTL_RUN_BIT] |=> !s_q.armed)
    else $error("wait not re-armed while stopped");
  arm_on_fall_a: assert property (@(posedge clock) disable iff (sys_rst)
    (extSel && s_q.control[TMRCTL_RUN_BIT] && fall && !regWrite) |=> s_q.armed)
    else $error("falling edge did not arm");
  sync_path_a: assert property (@(posedge clock) disable iff (sys_rst)
    !s_q.control[TMRCTL_SYNC_BIT] |-> pinLevel == s_q.pinAligned)
    else $error("sync path not selected");
  bypass_path_a: assert property (@(posedge clock) disable iff (sys_rst)
    s_q.control[TMRCTL_SYNC_BIT] |-> pinLevel == s_q.pinSync)
    else $error("bypass path not selected");

  // Prescaler
  div_one_a: assert property (@(posedge clock) disable iff (sys_rst)
    (psSel == TMRCTL_PS_DIV1) |-> psTick == srcTick)
    else $error("divide by one lost a tick");
  div_two_a: assert property (@(posedge clock) disable iff (sys_rst)
    (psSel == TMRCTL_PS_DIV2 && psTick) |-> s_q.prescale[0])
    else $error("divide by two wrong phase");
  div_four_a: assert property (@(posedge clock) disable iff (sys_rst)
    (psSel == TMRCTL_PS_DIV4 && psTick) |-> s_q.prescale[1:0] == 2'h3)
    else $error("divide by four wrong phase");
  div_eight_a: assert property (@(posedge clock) disable iff (sys_rst)
    (psSel == TMRCTL_PS_DIV8 && psTick) |-> s_q.prescale == 3'h7)
    else $error("divide by eight wrong phase");
  ps_restart_a: assert property (@(posedge clock) disable iff (sys_rst)
    (regWrite && regAddr == TMRCTL_CONTROL_OFS) |=> s_q.prescale == 3'h0)
    else $error("control write kept prescaler phase");

  // Register port
  osc_follow_a: assert property (@(posedge clock) disable iff (sys_rst)
    (regWrite && regAddr == TMRCTL_CONTROL_OFS) |=> oscPowerOn == $past(regWrData[TMRCTL_OSC_BIT]))
    else $error("oscillator enable not followed");
  ctrl_write_a: assert property (@(posedge clock) disable iff (sys_rst)
    (regWrite && regAddr == TMRCTL_CONTROL_OFS) |=> s_q.control == ($past(regWrData) & TMRCTL_CONTROL_MASK))
    else $error("control write lost");
  top_bits_a: assert property (@(posedge clock) disable iff (sys_rst)
    s_q.control[7:6] == 2'h0)
    else $error("unused control bits set");
  rd_ctrl_a: assert property (@(posedge clock) disable iff (sys_rst)
    (regRead && regAddr == TMRCTL_CONTROL_OFS) |=> regRdData == $past(s_q.control))
    else $error("control read wrong");
  rd_count_a: assert property (@(posedge clock) disable iff (sys_rst)
    (regRead && regAddr == TMRCTL_COUNT_LO_OFS) |=> regRdData == $past(s_q.count[7:0]))
    else $error("count low read wrong");
  rd_idle_a: assert property (@(posedge clock) disable iff (sys_rst)
    !regRead |=> regRdData == 8'h00)
    else $error("read data not cleared");

endmodule : tmrctl_timer

// ===== dv/tmrctl_ext_src.sv
// External count source: bursts of a square wave on the count pin.
// Assumes the bench clock; the pin rests low between bursts.
module tmrctl_ext_src #(parameter int TOGGLES = 10) (
  input wire logic clock,
  input wire logic start,
  output logic pin
);
  timeunit 1ns;
  timeprecision 1ps;
  int left = 0;
  int ph = 0;
  logic lvl = 1'b0;
  assign pin = lvl;
  // Each level holds three clocks, above the two that the synchroniser needs
  always @(posedge clock) begin
    if (start) begin
      left <= TOGGLES;
    end else if (left > 0) begin
      ph <= (ph + 1) % 3;
      if (ph == 2) begin
        lvl <= ~lvl;
        left <= left - 1;
      end
    end
  end
endmodule : tmrctl_ext_src

// ===== dv/tb_top.sv
// Self-checking bench for the timer control block: registers, internal and external counting.
// Assumes the source model drives the count pin; one 125 MHz clock.
module tb_top
  import tmrctl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0, sys_rst = 1'b1, regWrite = 1'b0, regRead = 1'b0, start = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWrData = 8'h00, regRdData, rdv, cv;
  logic oscPowerOn, pin;
  logic [15:0] countValue;
  logic [31:0] seed = 32'hf59bc277;
  int failures = 0, n_tests = 0;
  always #4 clock = ~clock;
  tmrctl_timer dut (.clock(clock), .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .externalCountPin(pin),
    .oscPowerOn(oscPowerOn), .countValue(countValue));
  tmrctl_ext_src #(.TOGGLES(10)) src (.clock(clock), .start(start), .pin(pin));
  task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  function automatic logic [31:0] xorshift(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    xorshift = y ^ (y << 5);
  endfunction : xorshift
  // A spare cycle after each strobe keeps one assignment per signal per step
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
    @(posedge clock);
  endtask : wr
  task automatic rdreg(input logic [3:0] a);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    #1 rdv = regRdData;
    @(posedge clock);
  endtask : rdreg
  task automatic final_report();
    if (failures == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : final_report
  // Stopping near a tick may land one count short
  task automatic near(input logic [15:0] e);
    chk("count", e, (countValue === e - 16'h1) ? e : countValue);
  endtask : near
  initial begin
    #50us;
    failures++;
    final_report();
  end
  initial begin
    repeat (8) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    #1 chk("count", TMRCTL_COUNT_RESET, countValue);
    rdreg(4'h3);
    chk("unmapped", 16'h0, {8'h0, rdv});
    for (int p = 0; p < 4; p++) begin
      seed = xorshift(seed);
      cv = {seed[7:6], p[1:0], seed[3:2], 2'b01};
      wr(TMRCTL_CONTROL_OFS, 8'h00);
      wr(TMRCTL_COUNT_LO_OFS, 8'hfa);
      wr(TMRCTL_COUNT_HI_OFS, 8'hff);
      wr(TMRCTL_CONTROL_OFS, cv);
      repeat ((32 << p) - 2) @(posedge clock);
      #1 near(16'h0002);
      chk("osc", {15'h0, cv[3]}, {15'h0, oscPowerOn});
      wr(TMRCTL_CONTROL_OFS, cv & 8'hfe);
      repeat (40) @(posedge clock);
      chk("count", 16'h0002, countValue);
      rdreg(TMRCTL_CONTROL_OFS);
      chk("control", {8'h0, cv & 8'hfe & TMRCTL_CONTROL_MASK}, {8'h0, rdv});
      rdreg(TMRCTL_COUNT_LO_OFS);
      chk("count lo", 16'h0002, {8'h0, rdv});
      rdreg(TMRCTL_COUNT_HI_OFS);
      chk("count hi", 16'h0000, {8'h0, rdv});
    end
    for (int s = 0; s < 2; s++) begin
      wr(TMRCTL_CONTROL_OFS, 8'h00);
      wr(TMRCTL_COUNT_LO_OFS, 8'h00);
      wr(TMRCTL_COUNT_HI_OFS, 8'h00);
      wr(TMRCTL_CONTROL_OFS, {5'h0, s[0], 2'b11});
      start <= 1'b1;
      @(posedge clock);
      start <= 1'b0;
      repeat (40) @(posedge clock);
      chk("ext count", 16'h0004, countValue);
    end
    final_report();
  end
endmodule : tb_top
